/* src/urx_pkg.sv */
// Shared constants and types for the asynchronous serial receive core
package urx_pkg;

  // APB address width and register byte offsets
  localparam int         APB_AW         = 5;
  localparam logic [4:0] OFS_CSR_A      = 5'h00;
  localparam logic [4:0] OFS_CSR_B      = 5'h04;
  localparam logic [4:0] OFS_CSR_C      = 5'h08;
  localparam logic [4:0] OFS_DATA       = 5'h0C;

  // Control and status register A fields
  localparam int BIT_RX_COMPLETE  = 7;
  localparam int BIT_FRAME_ERR    = 4;
  localparam int BIT_OVERRUN      = 3;
  localparam int BIT_PARITY_ERR   = 2;
  localparam int BIT_DOUBLE_SPEED = 1;

  // Control and status register B fields
  localparam int BIT_RXC_IRQ_EN   = 7;
  localparam int BIT_RX_ENABLE    = 4;
  localparam int BIT_NINTH        = 1;

  // Control and status register C fields
  localparam int BIT_PARITY_EN    = 5;
  localparam int BIT_PARITY_ODD   = 4;
  localparam int BIT_STOP_COUNT   = 3;
  localparam int CSZ_LSB          = 0;
  localparam int CSZ_W            = 3;

  // Reset values of the writable controls
  localparam logic       RST_DOUBLE_SPEED = 1'b0;
  localparam logic       RST_RX_ENABLE    = 1'b0;
  localparam logic       RST_RXC_IRQ_EN   = 1'b0;
  localparam logic [1:0] RST_PARITY_MODE  = 2'h0;
  localparam logic       RST_STOP_COUNT   = 1'b0;
  localparam logic [2:0] RST_CHAR_SIZE    = 3'h3;

  // Character size code for nine data bits
  localparam logic [2:0] CSZ_NINE = 3'h7;

  // Oversampling figures: samples per bit and first voting sample
  localparam logic [4:0] SPB_NORMAL = 5'h10;
  localparam logic [4:0] SPB_DOUBLE = 5'h08;
  localparam logic [4:0] SF_NORMAL  = 5'h08;
  localparam logic [4:0] SF_DOUBLE  = 5'h04;

  // Buffer depth and data width
  localparam int BUF_DEPTH = 2;
  localparam int DATA_W    = 9;

  // One buffered character with its own error marks
  typedef struct packed {
    logic              fe;
    logic              dor;
    logic              upe;
    logic [DATA_W-1:0] data;
  } urx_entry_t;

  // Receive state machine
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_START  = 3'b001,
    ST_DATA   = 3'b010,
    ST_PARITY = 3'b011,
    ST_STOP   = 3'b100
  } urx_state_t;

endpackage

/* src/urx_buf_if.sv */
// Connection between the receive logic and its character buffer
`timescale 1ns/1ps
interface urx_buf_if;
  import urx_pkg::*;
  logic       push;
  urx_entry_t push_data;
  logic       pop;
  logic       flush;
  logic       full;
  logic       empty;
  urx_entry_t head;

  modport fill  (output push, push_data, pop, flush, input full, empty, head);
  modport store (input push, push_data, pop, flush, output full, empty, head);
endinterface

/* src/urx_rx_buf.sv */
// Small receive character buffer with flush
`timescale 1ns/1ps
module urx_rx_buf #(
  parameter int DEPTH = urx_pkg::BUF_DEPTH
) (
  input  wire logic I_MCLK,
  input  wire logic I_RST,
  urx_buf_if.store  b
);
  import urx_pkg::*;

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  urx_entry_t      mem_reg [DEPTH];
  logic [PW-1:0]   wr_ptr_reg;
  logic [PW-1:0]   rd_ptr_reg;
  logic [CW-1:0]   count_reg;
  logic            do_push;
  logic            do_pop;

  // Pointer step with wrap at the buffer depth
  function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
    step = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign b.full  = (count_reg == CW'(DEPTH));
  assign b.empty = (count_reg == '0);
  assign b.head  = mem_reg[rd_ptr_reg];
  assign do_push = b.push & ~b.full;
  assign do_pop  = b.pop & ~b.empty;

  ////////////////////////////////////////////////////////////////////////////
  // Storage; no reset needed, stale slots are never visible
  always_ff @(posedge I_MCLK)
  begin
    if (do_push)
    begin
      mem_reg[wr_ptr_reg] <= b.push_data;
    end
  end

  // Pointers and fill level; flush empties the buffer at once
  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else if (b.flush)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (do_push)
      begin
        wr_ptr_reg <= step(wr_ptr_reg);
      end
      if (do_pop)
      begin
        rd_ptr_reg <= step(rd_ptr_reg);
      end
      count_reg <= count_reg + CW'(do_push) - CW'(do_pop);
    end
  end

endmodule

/* src/urx_receiver.sv */
// Asynchronous serial receiver core with APB registers
// Functional notes
// - Receive complete flag tracks unread buffer content
// - Clearing enable flushes the receive buffer
// - Interrupt requested while flag, enable, global on
// - Error flags stored per buffered character
// - Error flag writes ignored; software writes zeros
// - Error flags never raise interrupts
// - Frame error equals inverted first stop bit
// - Only the first stop bit is checked
// - Overrun: buffer full, shift waiting, new start
// - Overrun cleared when character enters buffer
// - Parity error reads zero when checking off
// - Upper mode bit enables, lower picks odd/even
// - Parity mark kept only if enabled on arrival
// - Disable is immediate, aborts frame, releases pin
// - Data read pops; read status and ninth first
// - Sixteen samples per bit, eight in double speed
// - Start vote on samples 8-10 or 4-6
// - Spike rejected, resync on each valid start
// - Sixteen or eight recovery states per bit
// - Three centre samples, majority decides each bit
// - Recover bits until stop, then store character
// - Centre samples 8,9,10 or 4,5,6
// - Stop bit majority voted, zero sets frame error
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module urx_receiver (
  input  wire logic                        I_MCLK,
  input  wire logic                        I_RST,
  input  wire logic                        I_SAMPLE_TICK,
  input  wire logic                        I_RXD,
  input  wire logic                        I_GLOBAL_IRQ_EN,
  input  wire logic                        I_PSEL,
  input  wire logic                        I_PENABLE,
  input  wire logic                        I_PWRITE,
  input  wire logic [urx_pkg::APB_AW-1:0]  I_PADDR,
  input  wire logic [31:0]                 I_PWDATA,
  output logic      [31:0]                 O_PRDATA,
  output logic                             O_PREADY,
  output logic                             O_PSLVERR,
  output logic                             O_RXC_IRQ,
  output logic                             O_RX_PIN_OVERRIDE
);
  import urx_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  urx_buf_if bi ();

  logic        double_speed_reg;
  logic        rx_enable_reg;
  logic        rxc_irq_en_reg;
  logic [1:0]  parity_mode_reg;
  logic        stop_count_reg;
  logic [2:0]  char_size_reg;

  urx_state_t  state_reg;
  logic [4:0]  cnt_reg;
  logic [3:0]  bit_idx_reg;
  logic        last_reg;
  logic        samp0_reg;
  logic        samp1_reg;
  logic [8:0]  shift_reg;
  logic        pbit_reg;
  logic        hold_valid_reg;
  urx_entry_t  hold_reg;
  logic        dor_pending_reg;

  logic [4:0]  spb;
  logic [4:0]  sf;
  logic        vote_point;
  logic        vote;
  logic        start_seen;
  logic        frame_done;
  logic        stop_vote;
  logic [3:0]  nbits;
  urx_entry_t  new_entry;
  logic        push_hold;
  logic        push_new;
  logic        setup;
  logic        access;
  logic        mapped;
  logic        data_read;
  logic [31:0] rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction

  function automatic logic hit(input logic [APB_AW-1:0] a, input logic [4:0] ofs);
    hit = (a == ofs);
  endfunction

  // Character size code to data bit count; reserved codes act as eight
  function automatic logic [3:0] data_bits(input logic [2:0] csz);
    if (csz == CSZ_NINE)
    begin
      data_bits = 4'h9;
    end
    else if (csz[2])
    begin
      data_bits = 4'h8;
    end
    else
    begin
      data_bits = 4'h5 + {2'h0, csz[1:0]};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Sampling geometry follows the speed mode
  assign spb        = double_speed_reg ? SPB_DOUBLE : SPB_NORMAL;
  assign sf         = double_speed_reg ? SF_DOUBLE : SF_NORMAL;
  assign vote_point = I_SAMPLE_TICK & (state_reg != ST_IDLE) & (cnt_reg == sf + 5'h02);
  assign vote       = maj3(samp0_reg, samp1_reg, I_RXD);
  assign nbits      = data_bits(char_size_reg);

  // Falling edge seen while hunting for a start bit
  assign start_seen = rx_enable_reg & I_SAMPLE_TICK & (state_reg == ST_IDLE)
                      & last_reg & ~I_RXD;
  assign frame_done = vote_point & (state_reg == ST_STOP);
  assign stop_vote  = vote;

  // Completed character with its own marks
  always_comb
  begin
    new_entry      = '0;
    new_entry.data = shift_reg;
    new_entry.fe   = ~stop_vote;
    new_entry.dor  = dor_pending_reg;
    new_entry.upe  = parity_mode_reg[1]
                     & ((^shift_reg) ^ pbit_reg ^ parity_mode_reg[0]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample counter and line history; restarts at one on each start edge
  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      cnt_reg   <= 5'h00;
      last_reg  <= 1'b1;
      samp0_reg <= 1'b1;
      samp1_reg <= 1'b1;
    end
    else if (!rx_enable_reg)
    begin
      cnt_reg  <= 5'h00;
      last_reg <= 1'b1;
    end
    else if (I_SAMPLE_TICK)
    begin
      last_reg <= I_RXD;
      if (start_seen)
      begin
        cnt_reg <= 5'h01;
      end
      else if (state_reg != ST_IDLE)
      begin
        cnt_reg <= (cnt_reg == spb) ? 5'h01 : cnt_reg + 5'h01;
      end
      // First two centre samples; the third is the live line
      if (cnt_reg == sf)
      begin
        samp0_reg <= I_RXD;
      end
      if (cnt_reg == sf + 5'h01)
      begin
        samp1_reg <= I_RXD;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame state machine; leaves at the stop vote so the next edge is caught early
  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      state_reg   <= ST_IDLE;
      bit_idx_reg <= 4'h0;
      shift_reg   <= 9'h000;
      pbit_reg    <= 1'b0;
    end
    else if (!rx_enable_reg)
    begin
      state_reg <= ST_IDLE;
    end
    else if (start_seen)
    begin
      state_reg   <= ST_START;
      bit_idx_reg <= 4'h0;
      shift_reg   <= 9'h000;                                        // Short sizes read high bits as zero
    end
    else if (vote_point)
    begin
      unique case (state_reg)
        ST_START:
        begin
          state_reg <= vote ? ST_IDLE : ST_DATA;
        end
        ST_DATA:
        begin
          shift_reg[bit_idx_reg] <= vote;
          bit_idx_reg            <= bit_idx_reg + 4'h1;
          if (bit_idx_reg == nbits - 4'h1)
          begin
            state_reg <= parity_mode_reg[1] ? ST_PARITY : ST_STOP;
          end
        end
        ST_PARITY:
        begin
          pbit_reg  <= vote;
          state_reg <= ST_STOP;
        end
        ST_STOP:
        begin
          state_reg <= ST_IDLE;
        end
        ST_IDLE:
        begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift holding stage and overrun tracking
  assign push_hold = hold_valid_reg & ~bi.full;
  assign push_new  = frame_done & ~bi.full & ~hold_valid_reg;

  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      hold_valid_reg  <= 1'b0;
      hold_reg        <= '0;
      dor_pending_reg <= 1'b0;
    end
    else if (!rx_enable_reg)
    begin
      hold_valid_reg  <= 1'b0;
      dor_pending_reg <= 1'b0;
    end
    else
    begin
      if (frame_done)
      begin
        dor_pending_reg <= 1'b0;
      end
      else if (start_seen & bi.full & hold_valid_reg)
      begin
        dor_pending_reg <= 1'b1;
      end
      // Waiting character is lost once a new frame starts shifting
      if (frame_done & ~push_new)
      begin
        hold_valid_reg <= 1'b1;
        hold_reg       <= new_entry;
      end
      else if (push_hold | (start_seen & bi.full))
      begin
        hold_valid_reg <= 1'b0;
      end
    end
  end

  // Buffer feed: held character first, then a fresh one
  assign bi.push      = push_hold | push_new;
  assign bi.push_data = push_hold ? hold_reg : new_entry;
  assign bi.pop       = data_read;
  assign bi.flush     = ~rx_enable_reg;

  urx_rx_buf #(
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .I_MCLK (I_MCLK),
    .I_RST  (I_RST),
    .b      (bi)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB decode; zero wait states
  assign setup     = I_PSEL & ~I_PENABLE;
  assign access    = I_PSEL & I_PENABLE;
  assign mapped    = hit(I_PADDR, OFS_CSR_A) | hit(I_PADDR, OFS_CSR_B)
                     | hit(I_PADDR, OFS_CSR_C) | hit(I_PADDR, OFS_DATA);
  assign data_read = access & ~I_PWRITE & hit(I_PADDR, OFS_DATA);
  assign O_PREADY  = 1'b1;
  assign O_PSLVERR = access & ~mapped;

  // Software controls; error bit positions take no write
  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      double_speed_reg <= RST_DOUBLE_SPEED;
      rx_enable_reg    <= RST_RX_ENABLE;
      rxc_irq_en_reg   <= RST_RXC_IRQ_EN;
      parity_mode_reg  <= RST_PARITY_MODE;
      stop_count_reg   <= RST_STOP_COUNT;
      char_size_reg    <= RST_CHAR_SIZE;
    end
    else if (access & I_PWRITE)
    begin
      if (hit(I_PADDR, OFS_CSR_A))
      begin
        double_speed_reg <= I_PWDATA[BIT_DOUBLE_SPEED];
      end
      if (hit(I_PADDR, OFS_CSR_B))
      begin
        rxc_irq_en_reg <= I_PWDATA[BIT_RXC_IRQ_EN];
        rx_enable_reg  <= I_PWDATA[BIT_RX_ENABLE];
      end
      if (hit(I_PADDR, OFS_CSR_C))
      begin
        parity_mode_reg <= I_PWDATA[BIT_PARITY_EN:BIT_PARITY_ODD];
        stop_count_reg  <= I_PWDATA[BIT_STOP_COUNT];
        char_size_reg   <= I_PWDATA[CSZ_LSB +: CSZ_W];
      end
    end
  end

  // Read view of the head character and controls
  always_comb
  begin
    rdata = 32'h0000_0000;
    if (hit(I_PADDR, OFS_CSR_A))
    begin
      rdata[BIT_RX_COMPLETE]  = ~bi.empty;
      rdata[BIT_FRAME_ERR]    = ~bi.empty & bi.head.fe;
      rdata[BIT_OVERRUN]      = ~bi.empty & bi.head.dor;
      rdata[BIT_PARITY_ERR]   = ~bi.empty & bi.head.upe & parity_mode_reg[1];
      rdata[BIT_DOUBLE_SPEED] = double_speed_reg;
    end
    else if (hit(I_PADDR, OFS_CSR_B))
    begin
      rdata[BIT_RXC_IRQ_EN] = rxc_irq_en_reg;
      rdata[BIT_RX_ENABLE]  = rx_enable_reg;
      rdata[BIT_NINTH]      = ~bi.empty & bi.head.data[8];
    end
    else if (hit(I_PADDR, OFS_CSR_C))
    begin
      rdata[BIT_PARITY_EN:BIT_PARITY_ODD] = parity_mode_reg;
      rdata[BIT_STOP_COUNT]               = stop_count_reg;
      rdata[CSZ_LSB +: CSZ_W]             = char_size_reg;
    end
    else if (hit(I_PADDR, OFS_DATA))
    begin
      rdata[7:0] = bi.empty ? 8'h00 : bi.head.data[7:0];
    end
  end

  // Read data captured in the setup cycle, before any pop moves the head
  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      O_PRDATA <= 32'h0000_0000;
    end
    else if (setup & ~I_PWRITE)
    begin
      O_PRDATA <= rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Level request; error flags deliberately take no part
  assign O_RXC_IRQ         = rxc_irq_en_reg & I_GLOBAL_IRQ_EN & ~bi.empty;
  assign O_RX_PIN_OVERRIDE = rx_enable_reg;

endmodule

/* sim/urx_receiver_props.sv */
// Port-level properties of the serial receive core
`timescale 1ns/1ps
module urx_receiver_props (
  input wire logic                       I_MCLK,
  input wire logic                       I_RST,
  input wire logic                       I_GLOBAL_IRQ_EN,
  input wire logic                       I_PSEL,
  input wire logic                       I_PENABLE,
  input wire logic                       I_PWRITE,
  input wire logic [urx_pkg::APB_AW-1:0] I_PADDR,
  input wire logic [31:0]                I_PWDATA,
  input wire logic [31:0]                O_PRDATA,
  input wire logic                       O_PREADY,
  input wire logic                       O_PSLVERR,
  input wire logic                       O_RXC_IRQ,
  input wire logic                       O_RX_PIN_OVERRIDE
);
  import urx_pkg::*;
  logic acc;
  logic mapped;
  logic wr_b;
  logic rd_setup;
  // Bus phase decode shared by the properties below
  assign acc = I_PSEL && I_PENABLE;
  assign mapped = I_PADDR inside {OFS_CSR_A, OFS_CSR_B, OFS_CSR_C, OFS_DATA};
  assign wr_b = acc && I_PWRITE && (I_PADDR == OFS_CSR_B);
  assign rd_setup = I_PSEL && !I_PENABLE && !I_PWRITE;
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (I_RST);
  ////////////////////////////////////////////////////////////////////////////////
  // Zero-wait slave, error only on a hole in the map
  a_ready_always: assert property (O_PREADY)
    else $error("pready dropped");
  a_slverr_decode: assert property (acc |-> O_PSLVERR == !mapped)
    else $error("slave error disagrees with address decode");
  a_slverr_idle: assert property (!acc |-> !O_PSLVERR)
    else $error("slave error outside access phase");
  // Read data only moves when a read is set up
  a_prdata_hold: assert property (!rd_setup |=> $stable(O_PRDATA))
    else $error("read data changed without a read");
  // Pin takeover follows the enable bit at once and only then
  a_enable_write: assert property (wr_b |=>
      O_RX_PIN_OVERRIDE == $past(I_PWDATA[BIT_RX_ENABLE]))
    else $error("pin takeover not equal to written enable");
  a_enable_hold: assert property (!wr_b |=> $stable(O_RX_PIN_OVERRIDE))
    else $error("pin takeover changed without a write");
  // Disabled receiver leaves nothing to request service for
  a_flush_irq: assert property (!O_RX_PIN_OVERRIDE |=> !O_RXC_IRQ)
    else $error("request while receiver disabled");
  a_irq_gate: assert property (!I_GLOBAL_IRQ_EN |-> !O_RXC_IRQ)
    else $error("request with global enable off");
  a_irq_rise: assert property ($rose(O_RXC_IRQ) |-> O_RX_PIN_OVERRIDE)
    else $error("request rose with receiver off");
  // Request only ends through a data read, a write, or global disable
  a_irq_fall: assert property ($fell(O_RXC_IRQ) |->
      $past(acc && (I_PWRITE || I_PADDR == OFS_DATA)) || $fell(I_GLOBAL_IRQ_EN) ||
      $past(acc && I_PWRITE, 2))
    else $error("request dropped with no cause");
endmodule

bind urx_receiver urx_receiver_props urx_receiver_props_i (
  .I_MCLK(I_MCLK), .I_RST(I_RST), .I_GLOBAL_IRQ_EN(I_GLOBAL_IRQ_EN), .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
  .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_RXC_IRQ(O_RXC_IRQ),
  .O_RX_PIN_OVERRIDE(O_RX_PIN_OVERRIDE));

/* sim/urx_tx_model.sv */
// Remote serial transmitter model driving the receive line
`timescale 1ns/1ps
module urx_tx_model (
  input  wire logic        i_clk,
  input  wire logic        i_tick,
  input  wire logic        i_go,
  input  wire logic [15:0] i_frame,
  input  wire logic [4:0]  i_nbits,
  input  wire logic [4:0]  i_unit,
  output logic             o_rxd,
  output logic             o_busy
);
  logic [15:0] sh_reg;
  logic [4:0]  left_reg;
  logic [4:0]  sub_reg;
  logic        cur_reg = 1'b1;
  logic        busy_reg = 1'b0;
  // Line pulled up whenever no frame is in flight
  assign o_rxd = busy_reg ? cur_reg : 1'b1;
  assign o_busy = busy_reg;
  // One element per i_unit ticks, first element first; a short unit makes a spike
  always @(posedge i_clk)
  begin
    if (i_go)
    begin
      sh_reg <= i_frame;
      left_reg <= i_nbits;
      sub_reg <= 5'h00;
      cur_reg <= 1'b1;
      busy_reg <= 1'b1;
    end
    else if (busy_reg && i_tick)
    begin
      cur_reg <= sh_reg[0];
      if (sub_reg == i_unit - 5'h01)
      begin
        sub_reg <= 5'h00;
        sh_reg <= sh_reg >> 1;
        left_reg <= left_reg - 5'h01;
        busy_reg <= (left_reg != 5'h01);
      end
      else
        sub_reg <= sub_reg + 5'h01;
    end
  end
endmodule

/* sim/tb.sv */
// Self-checking bench for the serial receive core
`timescale 1ns/1ps
module tb;
  import urx_pkg::*;
  logic              mclk = 1'b0;
  logic              rst = 1'b1;
  logic              tick = 1'b0;
  logic              gie = 1'b1;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = 5'h00;
  logic [31:0]       pwdata = 32'h0000_0000;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              irq;
  logic              ovr;
  logic              go = 1'b0;
  logic [15:0]       frame = 16'hFFFF;
  logic [4:0]        nbits = 5'h01;
  logic [4:0]        unit = 5'h10;
  logic              rxd;
  logic              busy;
  int                error_cnt = 0;
  int                n_compared = 0;
  int                i;

  always #5 mclk = ~mclk;
  // Oversample tick every other clock, so tick and clock stay distinct
  always @(posedge mclk) tick <= ~tick;

  urx_receiver urx_receiver_i (.I_MCLK(mclk), .I_RST(rst), .I_SAMPLE_TICK(tick), .I_RXD(rxd),
    .I_GLOBAL_IRQ_EN(gie), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .O_RXC_IRQ(irq), .O_RX_PIN_OVERRIDE(ovr));
  urx_tx_model urx_tx_model_i (.i_clk(mclk), .i_tick(tick), .i_go(go), .i_frame(frame),
    .i_nbits(nbits), .i_unit(unit), .o_rxd(rxd), .o_busy(busy));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready seen at an edge
  task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] wd,
                     output logic [31:0] rdv, output logic err);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [APB_AW-1:0] a, input logic [7:0] d);
    logic [31:0] x;
    logic        e;
    apb(1'b1, a, {24'h00_0000, d}, x, e);
  endtask

  task automatic rd(input logic [APB_AW-1:0] a, input logic [7:0] exp, input logic xe);
    logic [31:0] x;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, x, e);
    chk(x, {24'h00_0000, exp});
    chk({31'h0000_0000, e}, {31'h0000_0000, xe});
  endtask

  // Hand a frame to the transmitter and wait until the line is idle again
  task automatic drive(input logic [15:0] f, input logic [4:0] n, input logic [4:0] u);
    @(posedge mclk);
    frame <= f;
    nbits <= n;
    unit <= u;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    do @(posedge mclk); while (busy);
  endtask

  // Start, data first bit first, optional parity, one stop, one idle element
  task automatic send(input logic [8:0] d, input int nd, input logic par, input logic odd,
                      input logic bad, input logic stp, input logic [4:0] u);
    logic [15:0] f;
    int          k;
    f = 16'hFFFE;
    for (k = 0; k < nd; k++) f[k+1] = d[k];
    k = nd + 1;
    if (par)
    begin
      f[k] = ^(d & ((9'h001 << nd) - 9'h001)) ^ odd ^ bad;
      k++;
    end
    f[k] = stp;
    drive(f, 5'(k + 2), u);
  endtask

  task automatic print_verdict;
    $display("Compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Hang guard, well above the twenty or so frames' worth of cycles needed
  initial
  begin
    #400_000;
    error_cnt++;
    print_verdict();
  end

  initial
  begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    rd(OFS_CSR_A, 8'h00, 1'b0);
    rd(OFS_CSR_B, 8'h00, 1'b0);
    rd(OFS_CSR_C, 8'h03, 1'b0);
    rd(5'h10, 8'h00, 1'b1);
    wr(OFS_CSR_B, 8'h90);
    wr(OFS_CSR_C, 8'h2B);
    send(9'h0A5, 8, 1'b1, 1'b0, 1'b0, 1'b1, 5'h10);
    send(9'h03C, 8, 1'b1, 1'b0, 1'b1, 1'b1, 5'h10);
    send(9'h05A, 8, 1'b1, 1'b0, 1'b0, 1'b0, 5'h10);
    rd(OFS_CSR_A, 8'h80, 1'b0);
    rd(OFS_DATA, 8'hA5, 1'b0);
    rd(OFS_CSR_A, 8'h84, 1'b0);
    rd(OFS_DATA, 8'h3C, 1'b0);
    rd(OFS_CSR_A, 8'h90, 1'b0);
    rd(OFS_DATA, 8'h5A, 1'b0);
    rd(OFS_CSR_A, 8'h00, 1'b0);
    send(9'h03C, 8, 1'b1, 1'b0, 1'b1, 1'b1, 5'h10);
    wr(OFS_CSR_A, 8'h1C);
    rd(OFS_CSR_A, 8'h84, 1'b0);
    wr(OFS_CSR_C, 8'h0B);
    rd(OFS_CSR_A, 8'h80, 1'b0);
    rd(OFS_DATA, 8'h3C, 1'b0);
    send(9'h03D, 8, 1'b0, 1'b0, 1'b0, 1'b1, 5'h10);
    wr(OFS_CSR_C, 8'h2B);
    rd(OFS_CSR_A, 8'h80, 1'b0);
    rd(OFS_DATA, 8'h3D, 1'b0);
    wr(OFS_CSR_C, 8'h33);
    send(9'h081, 8, 1'b1, 1'b1, 1'b0, 1'b1, 5'h10);
    send(9'h081, 8, 1'b1, 1'b0, 1'b0, 1'b1, 5'h10);
    rd(OFS_CSR_A, 8'h80, 1'b0);
    rd(OFS_DATA, 8'h81, 1'b0);
    rd(OFS_CSR_A, 8'h84, 1'b0);
    rd(OFS_DATA, 8'h81, 1'b0);
    // Four frames with no reads: the third is lost, the fourth carries the mark
    wr(OFS_CSR_C, 8'h03);
    for (i = 1; i <= 4; i++) send(9'(i * 17), 8, 1'b0, 1'b0, 1'b0, 1'b1, 5'h10);
    rd(OFS_CSR_A, 8'h80, 1'b0);
    rd(OFS_DATA, 8'h11, 1'b0);
    rd(OFS_CSR_A, 8'h80, 1'b0);
    rd(OFS_DATA, 8'h22, 1'b0);
    rd(OFS_CSR_A, 8'h88, 1'b0);
    rd(OFS_DATA, 8'h44, 1'b0);
    send(9'h055, 8, 1'b0, 1'b0, 1'b0, 1'b1, 5'h10);
    rd(OFS_CSR_A, 8'h80, 1'b0);
    rd(OFS_DATA, 8'h55, 1'b0);
    drive(16'hFFFE, 5'h02, 5'h04);
    rd(OFS_CSR_A, 8'h00, 1'b0);
    send(9'h066, 8, 1'b0, 1'b0, 1'b0, 1'b1, 5'h10);
    rd(OFS_DATA, 8'h66, 1'b0);
    wr(OFS_CSR_A, 8'h02);
    send(9'h099, 8, 1'b0, 1'b0, 1'b0, 1'b1, 5'h08);
    rd(OFS_CSR_A, 8'h82, 1'b0);
    rd(OFS_DATA, 8'h99, 1'b0);
    wr(OFS_CSR_A, 8'h00);
    wr(OFS_CSR_C, 8'h07);
    send(9'h1C3, 9, 1'b0, 1'b0, 1'b0, 1'b1, 5'h10);
    rd(OFS_CSR_B, 8'h92, 1'b0);
    rd(OFS_DATA, 8'hC3, 1'b0);
    wr(OFS_CSR_C, 8'h03);
    send(9'h012, 8, 1'b0, 1'b0, 1'b0, 1'b1, 5'h10);
    send(9'h034, 8, 1'b0, 1'b0, 1'b0, 1'b1, 5'h10);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    gie <= 1'b0;
    @(posedge mclk);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    gie <= 1'b1;
    wr(OFS_CSR_B, 8'h80);
    rd(OFS_CSR_A, 8'h00, 1'b0);
    chk({31'h0000_0000, ovr}, 32'h0000_0000);
    wr(OFS_CSR_B, 8'h90);
    // Disable in mid-frame: the rest of the frame must never arrive
    fork
      send(9'h0FF, 8, 1'b0, 1'b0, 1'b0, 1'b1, 5'h10);
      begin
        repeat (80) @(posedge mclk);
        wr(OFS_CSR_B, 8'h80);
        wr(OFS_CSR_B, 8'h90);
      end
    join
    rd(OFS_CSR_A, 8'h00, 1'b0);
    print_verdict();
  end
endmodule
